// ==== verilog/fsac_top.sv ====
// Flash sector access controller: array, protection, guard and link pin ownership
//
// How it works
// - The array erases whole or per sector and programs single bytes, leaving other sectors alone.
// - The number of sectors is one, two or three depending on the flash size.
// - Sectors zero and one are four kilobytes each at the top of the address space.
// - Sector zero covers F000h to FFFFh where the vectors live.
// - In application programming mode sector zero cannot be written or erased.
// - Socket and in-circuit modes may alter every sector and the option byte.
// - With read-out protection set, external reads return nothing and flash writes are refused.
// - Clearing read-out protection first erases the whole array, then allows programming.
// - Read-out protection lives in a dedicated bit of the option byte.
// - A two-key write guard must be passed before each program or erase command.
// - With the tool attached the serial clock and data pins belong to the link only.
// - The control/status register resets to zero and is for tool software.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
module fsac_top
  import fsac_pkg::*;
(
  // System
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Register port
  input  wire fsac_pkg::fsac_bus_s BUS,
  output logic [7:0]       RDATA,
  // Mode straps
  input  wire logic        PROG_MODE_SELECT,
  input  wire logic        IAP_ACTIVE,
  // Programming link
  input  wire logic        PROG_SERIAL_CLOCK,
  input  wire logic        PROG_SERIAL_DATA_I,
  output logic             PROG_SERIAL_DATA_O,
  output logic             PROG_SERIAL_DATA_OE_N,
  // Application side of shared pins
  input  wire logic        APP_DATA_O,
  output logic             APP_DATA_I,
  output logic             PINS_OWNED
);
  import fsac_pkg::*;

  localparam int unsigned DEPTH = FLASH_KB * 1024;
  localparam int          AW    = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: only a toggle crosses, so no word spans the two clocks
  logic       link_tog_q;
  always_ff @(posedge PROG_SERIAL_CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      link_tog_q <= 1'b0;
    else
      link_tog_q <= ~link_tog_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, level counts when stages two and three agree; the link toggle counts when they differ
  logic [2:0] sel_sync_q;
  logic [2:0] tog_sync_q;
  logic [2:0] iap_sync_q;
  logic [2:0] dat_sync_q;
  logic       pin_dat_q;
  logic       sel_q;
  logic       iap_q;
  logic       attached_q;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sel_sync_q <= 3'h0;
      tog_sync_q <= 3'h0;
      iap_sync_q <= 3'h0;
      dat_sync_q <= 3'h0;
      pin_dat_q  <= 1'b0;
      sel_q      <= 1'b0;
      iap_q      <= 1'b0;
      attached_q <= 1'b0;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[1:0], PROG_MODE_SELECT};
      tog_sync_q <= {tog_sync_q[1:0], link_tog_q};
      iap_sync_q <= {iap_sync_q[1:0], IAP_ACTIVE};
      dat_sync_q <= {dat_sync_q[1:0], PROG_SERIAL_DATA_I};
      if (dat_sync_q[1] == dat_sync_q[2])
        pin_dat_q <= dat_sync_q[2];
      if (sel_sync_q[1] == sel_sync_q[2])
        sel_q <= sel_sync_q[2];
      if (iap_sync_q[1] == iap_sync_q[2])
        iap_q <= iap_sync_q[2];
      // Any link clock rising edge or select marks the tool as present until reset
      if (sel_q || (tog_sync_q[1] != tog_sync_q[2]))
        attached_q <= 1'b1;
    end
  end

  fsac_mode_e mode;
  always_comb
  begin
    if (sel_q)
      mode = MODE_ICP;
    else if (iap_q)
      mode = MODE_IAP;
    else
      mode = MODE_SOCKET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]    ctrl_q;
  logic [7:0]    option_q;
  logic [1:0]    guard_q;
  logic [15:0]   addr_q;
  logic [7:0]    data_q;
  logic          deny_q;
  fsac_state_e   state_q;
  logic [AW-1:0] wipe_q;
  logic [7:0]    mem [DEPTH];
  logic          protect;
  assign protect = option_q[OPT_PROT_BIT];

  // Sector decode
  function automatic logic [1:0] sect_of(input logic [15:0] a);
    if (a >= SECT0_BASE)
      sect_of = 2'd0;
    else if (a >= SECT1_BASE)
      sect_of = 2'd1;
    else
      sect_of = 2'd2;
  endfunction

  logic [1:0] tgt_sect;
  logic       in_array;
  logic       sect_ok;
  logic       allowed;
  assign tgt_sect = sect_of(addr_q);
  assign in_array = addr_q >= FLASH_BASE;
  assign sect_ok  = in_array && (tgt_sect < NUM_SECTORS);
  // IN_APPLICATION_PROGRAMMING may not alter sector zero; socket and IN_CIRCUIT_PROGRAMMING may alter all
  assign allowed  = sect_ok && !protect && !((mode == MODE_IAP) && (tgt_sect == 2'd0));

  logic wr_ctrl;
  logic armed;
  logic cmd_any;
  assign wr_ctrl = BUS.wr && (BUS.addr == OFF_CTRL);
  assign armed   = guard_q == 2'd2;
  assign cmd_any = |BUS.wdata[CTRL_OPT_PGM:CTRL_PGM_BIT];

  // Guard sequence: two keys in order, consumed by the next control write
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      guard_q <= 2'd0;
    else if (BUS.wr && (BUS.addr == OFF_GUARD))
    begin
      if (BUS.wdata == GUARD_KEY1)
        guard_q <= 2'd1;
      else if ((BUS.wdata == GUARD_KEY2) && (guard_q == 2'd1))
        guard_q <= 2'd2;
      else
        guard_q <= 2'd0;
    end
    else if (wr_ctrl)
      guard_q <= 2'd0;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end
    else if (BUS.wr && (BUS.addr == OFF_ADDR_HI))
      addr_q[15:8] <= BUS.wdata;
    else if (BUS.wr && (BUS.addr == OFF_ADDR_LO))
      addr_q[7:0] <= BUS.wdata;
    else if (BUS.wr && (BUS.addr == OFF_DATA))
      data_q <= BUS.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
      ctrl_q  <= CTRL_RESET;
      deny_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (wr_ctrl && armed && cmd_any)
          begin
            deny_q <= 1'b0;
            if (BUS.wdata[CTRL_OPT_PGM])
              state_q <= (mode == MODE_IAP) ? ST_IDLE : ST_OPTION;
            else if (BUS.wdata[CTRL_MASS_ER])
              state_q <= (!protect && mode != MODE_IAP) ? ST_ERASE : ST_IDLE;
            else if (BUS.wdata[CTRL_SECT_ER])
              state_q <= allowed ? ST_ERASE : ST_IDLE;
            else
              state_q <= allowed ? ST_PGM : ST_IDLE;
            if ((BUS.wdata[CTRL_OPT_PGM] && mode == MODE_IAP) ||
                (!BUS.wdata[CTRL_OPT_PGM] && !allowed))
              deny_q <= 1'b1;
            ctrl_q[CTRL_OPT_PGM:CTRL_PGM_BIT] <= BUS.wdata[CTRL_OPT_PGM:CTRL_PGM_BIT];
          end
          else if (wr_ctrl && cmd_any)
            deny_q <= 1'b1;
        end
        ST_OPTION:
          // Removing protection must wipe the array first
          state_q <= (protect && !data_q[OPT_PROT_BIT]) ? ST_WIPE : ST_IDLE;
        ST_WIPE:
          if (wipe_q == AW'(DEPTH - 1))
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
      if (state_q != ST_IDLE && state_q != ST_WIPE && state_q != ST_OPTION)
        ctrl_q[CTRL_OPT_PGM:CTRL_PGM_BIT] <= 4'h0;
      if (state_q == ST_OPTION && !(protect && !data_q[OPT_PROT_BIT]))
        ctrl_q[CTRL_OPT_PGM:CTRL_PGM_BIT] <= 4'h0;
      if (state_q == ST_WIPE && wipe_q == AW'(DEPTH - 1))
        ctrl_q[CTRL_OPT_PGM:CTRL_PGM_BIT] <= 4'h0;
    end
  end

  // Option byte: protection stays until the wipe has finished
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      option_q <= OPTION_RESET;
    else if (state_q == ST_OPTION && !(protect && !data_q[OPT_PROT_BIT]))
      option_q <= data_q;
    else if (state_q == ST_WIPE && wipe_q == AW'(DEPTH - 1))
      option_q <= data_q;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      wipe_q <= '0;
    else if (state_q == ST_WIPE)
      wipe_q <= wipe_q + AW'(1);
    else
      wipe_q <= '0;
  end

  // Array storage, no reset on the memory itself
  logic [AW-1:0] mem_idx;
  logic [15:0]   addr_off;
  assign addr_off = addr_q - FLASH_BASE;
  assign mem_idx  = addr_off[AW-1:0];
  always_ff @(posedge REF_CLK)
  begin
    if (state_q == ST_PGM)
      mem[mem_idx] <= mem[mem_idx] & data_q;
    else if (state_q == ST_WIPE)
      mem[wipe_q] <= ERASED_BYTE;
    else if (state_q == ST_ERASE)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (ctrl_q[CTRL_MASS_ER] || sect_of(FLASH_BASE + 16'(i)) == tgt_sect)
          mem[i] <= ERASED_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  logic [7:0] status;
  assign status = {attached_q, protect, deny_q, (state_q != ST_IDLE), ctrl_q[3:0]};
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      RDATA <= 8'h00;
    else if (BUS.rd)
    begin
      if (BUS.addr == OFF_CTRL)
        RDATA <= status;
      else if (BUS.addr == OFF_ADDR_HI)
        RDATA <= addr_q[15:8];
      else if (BUS.addr == OFF_ADDR_LO)
        RDATA <= addr_q[7:0];
      else if (BUS.addr == OFF_DATA)
        RDATA <= data_q;
      else if (BUS.addr == OFF_OPTION)
        RDATA <= option_q;
      else if (BUS.addr == OFF_READ)
        // External extraction blocked while protected
        RDATA <= (protect || !in_array) ? 8'h00 : mem[mem_idx];
      else
        RDATA <= 8'h00;
    end
    else
      RDATA <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin ownership
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PROG_SERIAL_DATA_O    <= 1'b0;
      PROG_SERIAL_DATA_OE_N <= 1'b1;
      APP_DATA_I            <= 1'b0;
      PINS_OWNED            <= 1'b0;
    end
    else
    begin
      PINS_OWNED            <= attached_q;
      APP_DATA_I            <= attached_q ? 1'b0 : pin_dat_q;
      PROG_SERIAL_DATA_O    <= attached_q ? 1'b0 : APP_DATA_O;
      PROG_SERIAL_DATA_OE_N <= attached_q;
    end
  end
endmodule

// ==== verilog/fsac_pkg.sv ====
// Package of constants and types for the flash sector access controller
package fsac_pkg;
  // Flash size in kilobytes selects the available sectors
  localparam int unsigned FLASH_KB        = 16;
  localparam logic [15:0] SECT0_BASE      = 16'hf000;
  localparam logic [15:0] SECT1_BASE      = 16'he000;
  localparam logic [1:0]  NUM_SECTORS     = (FLASH_KB <= 4) ? 2'h1 :
                                            (FLASH_KB <= 8) ? 2'h2 : 2'h3;
  localparam logic [15:0] FLASH_BASE      = 16'h0000 - 16'(FLASH_KB * 1024);
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;

  // Register map, byte offsets on the plain register port
  localparam logic [3:0]  OFF_CTRL        = 4'h0;
  localparam logic [3:0]  OFF_GUARD       = 4'h1;
  localparam logic [3:0]  OFF_ADDR_HI     = 4'h2;
  localparam logic [3:0]  OFF_ADDR_LO     = 4'h3;
  localparam logic [3:0]  OFF_DATA        = 4'h4;
  localparam logic [3:0]  OFF_OPTION      = 4'h5;
  localparam logic [3:0]  OFF_READ        = 4'h6;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  OPTION_RESET    = 8'h00;

  // Control register fields
  localparam int          CTRL_PGM_BIT    = 0;
  localparam int          CTRL_SECT_ER    = 1;
  localparam int          CTRL_MASS_ER    = 2;
  localparam int          CTRL_OPT_PGM    = 3;
  localparam int          CTRL_BUSY_BIT   = 4;
  localparam int          CTRL_DENY_BIT   = 5;
  localparam int          CTRL_PROT_BIT   = 6;
  localparam int          CTRL_LINK_BIT   = 7;
  localparam int          OPT_PROT_BIT    = 0;

  // Guard unlock sequence
  localparam logic [7:0]  GUARD_KEY1      = 8'h56;
  localparam logic [7:0]  GUARD_KEY2      = 8'hae;

  typedef enum logic [1:0] {
    MODE_SOCKET = 2'b00,
    MODE_ICP    = 2'b01,
    MODE_IAP    = 2'b10
  } fsac_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PGM    = 3'b001,
    ST_ERASE  = 3'b010,
    ST_OPTION = 3'b011,
    ST_WIPE   = 3'b100
  } fsac_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fsac_bus_s;
endpackage

// ==== test/fsac_checker_props.sv ====
// Checker for the flash sector access controller ports
`timescale 1ns/10ps
module fsac_checker
  import fsac_pkg::*;
(
  // System
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  // Register port
  input wire fsac_pkg::fsac_bus_s BUS,
  input wire logic [7:0] RDATA,
  // Mode straps
  input wire logic       PROG_MODE_SELECT,
  input wire logic       IAP_ACTIVE,
  // Programming link
  input wire logic       PROG_SERIAL_CLOCK,
  input wire logic       PROG_SERIAL_DATA_I,
  input wire logic       PROG_SERIAL_DATA_O,
  input wire logic       PROG_SERIAL_DATA_OE_N,
  // Shared pins
  input wire logic       APP_DATA_O,
  input wire logic       APP_DATA_I,
  input wire logic       PINS_OWNED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic guard_seen_q;
  // Any guard write counts, so a deny is only demanded when clearly unguarded
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      guard_seen_q <= 1'b0;
    else if (BUS.wr && BUS.addr == OFF_GUARD)
      guard_seen_q <= 1'b1;
    else if (BUS.wr && BUS.addr == OFF_CTRL)
      guard_seen_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(BUS.rd) && $past(BUS.addr) > OFF_READ
    |-> RDATA == 8'h00) else $error("unmapped read not zero");
  a_status_attached: assert property ($past(BUS.rd) && $past(BUS.addr) == OFF_CTRL
    && $past(PINS_OWNED, 2) |-> RDATA[CTRL_LINK_BIT]) else $error("attach not in status");
  a_unguarded_deny: assert property ((BUS.wr && BUS.addr == OFF_CTRL && !guard_seen_q
    && BUS.wdata[3:0] != 4'h0) ##1 (BUS.rd && BUS.addr == OFF_CTRL)
    |=> RDATA[CTRL_DENY_BIT]) else $error("unguarded command not denied");
  a_pins_sticky: assert property (PINS_OWNED |=> PINS_OWNED)
    else $error("pin ownership dropped");
  a_app_isolated: assert property (PINS_OWNED |-> APP_DATA_I == 1'b0)
    else $error("application sees link pin");
  a_link_released: assert property (PINS_OWNED |-> PROG_SERIAL_DATA_OE_N)
    else $error("link data driven while attached");
  a_app_drives_pin: assert property (!PINS_OWNED && $past(RST_N)
    |-> !PROG_SERIAL_DATA_OE_N && PROG_SERIAL_DATA_O == $past(APP_DATA_O))
    else $error("application data not on pin");
  a_select_attach: assert property ($rose(PROG_MODE_SELECT) |-> ##[1:8] PINS_OWNED)
    else $error("select did not attach");
  a_clock_attach: assert property ($changed(PROG_SERIAL_CLOCK) |-> ##[1:12] PINS_OWNED)
    else $error("link clock did not attach");
endmodule
bind fsac_top fsac_checker u_fsac_checker (.REF_CLK(REF_CLK), .RST_N(RST_N), .BUS(BUS),
  .RDATA(RDATA), .PROG_MODE_SELECT(PROG_MODE_SELECT), .IAP_ACTIVE(IAP_ACTIVE),
  .PROG_SERIAL_CLOCK(PROG_SERIAL_CLOCK), .PROG_SERIAL_DATA_I(PROG_SERIAL_DATA_I),
  .PROG_SERIAL_DATA_O(PROG_SERIAL_DATA_O), .PROG_SERIAL_DATA_OE_N(PROG_SERIAL_DATA_OE_N),
  .APP_DATA_O(APP_DATA_O), .APP_DATA_I(APP_DATA_I), .PINS_OWNED(PINS_OWNED));

// ==== test/fsac_tool_model.sv ====
// Behavioural external programming tool on the serial link
`timescale 1ns/10ps
module fsac_tool_model (
  // Session control
  input  wire logic attach,
  // Link pins
  output logic      sel,
  output logic      sclk,
  output logic      sdat
);
  logic [7:0] frame_q;
  initial
  begin
    sel = 1'b0;
    sclk = 1'b0;
    sdat = 1'b1;
    frame_q = 8'ha5;
  end
  // Select comes first; clock stands still outside the frame
  always @(posedge attach)
  begin
    sel = 1'b1;
    #200;
    for (int i = 0; i < 8; i++)
    begin
      sdat = frame_q[7 - i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    // Released line shows the inverse, never a stale copy
    sdat = ~sdat;
  end
endmodule

// ==== test/test_flash_sector_access_control.sv ====
// Self-checking bench for the flash sector access controller
`timescale 1ns/10ps
module test_flash_sector_access_control;
  import fsac_pkg::*;
  logic       REF_CLK = 1'b0;
  logic       RST_N = 1'b0;
  fsac_bus_s  bus_q = '0;
  logic [7:0] RDATA;
  logic       iap_q = 1'b0;
  logic       app_q = 1'b0;
  logic       attach = 1'b0;
  logic       sel, sclk, tdat, dat_o, dat_oe_n, app_i, owned;
  logic [7:0] v;
  int         n_fail = 0;
  int         checks_done = 0;
  int         cycles = 0;
  wire        link_dat = dat_oe_n ? tdat : dat_o;
  always #20 REF_CLK = ~REF_CLK;
  fsac_top u_fsac_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .BUS(bus_q), .RDATA(RDATA),
    .PROG_MODE_SELECT(sel), .IAP_ACTIVE(iap_q), .PROG_SERIAL_CLOCK(sclk),
    .PROG_SERIAL_DATA_I(link_dat), .PROG_SERIAL_DATA_O(dat_o),
    .PROG_SERIAL_DATA_OE_N(dat_oe_n), .APP_DATA_O(app_q), .APP_DATA_I(app_i),
    .PINS_OWNED(owned));
  fsac_tool_model u_fsac_tool_model (.attach(attach), .sel(sel), .sclk(sclk), .sdat(tdat));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge REF_CLK);
    bus_q <= '{a, d, w, r};
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    put(a, d, 1'b1, 1'b0);
    put(4'h0, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a);
    put(a, 8'h00, 1'b0, 1'b1);
    put(4'h0, 8'h00, 1'b0, 1'b0);
    #1 v = RDATA;
  endtask
  // Keys and command back to back, then poll busy under a bound
  task automatic cmd(input logic [7:0] c);
    int i;
    put(OFF_GUARD, GUARD_KEY1, 1'b1, 1'b0);
    put(OFF_GUARD, GUARD_KEY2, 1'b1, 1'b0);
    put(OFF_CTRL, c, 1'b1, 1'b0);
    put(4'h0, 8'h00, 1'b0, 1'b0);
    i = 0;
    rd(OFF_CTRL);
    while (v[CTRL_BUSY_BIT] !== 1'b0 && i < 10000)
    begin
      rd(OFF_CTRL);
      i++;
    end
    chk(8'(v[CTRL_BUSY_BIT]), 8'h00);
  endtask
  task automatic at(input logic [15:0] a, input logic [7:0] d);
    wr(OFF_ADDR_HI, a[15:8]);
    wr(OFF_ADDR_LO, a[7:0]);
    wr(OFF_DATA, d);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    at(a, d);
    cmd(8'h01);
  endtask
  task automatic peek(input logic [15:0] a, input logic [7:0] exp);
    at(a, 8'h00);
    rd(OFF_READ);
    chk(v, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_socket;
    rd(OFF_CTRL);
    chk(v, CTRL_RESET);
    rd(4'hf);
    chk(v, 8'h00);
    cmd(8'h04);
    prog(16'hf000, 8'h5a);
    prog(16'hf000, 8'h0f);
    peek(16'hf000, 8'h0a);
    prog(16'hefff, 8'h11);
    at(16'hf000, 8'h00);
    cmd(8'h02);
    peek(16'hf000, ERASED_BYTE);
    peek(16'hefff, 8'h11);
    prog(16'hf001, 8'h77);
  endtask
  task automatic t_iap;
    iap_q <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    prog(16'hf000, 8'h00);
    peek(16'hf000, ERASED_BYTE);
    at(16'hf001, 8'h00);
    cmd(8'h02);
    peek(16'hf001, 8'h77);
    cmd(8'h04);
    peek(16'hefff, 8'h11);
    prog(16'hefff, 8'h01);
    peek(16'hefff, 8'h01);
    prog(FLASH_BASE, 8'h21);
    peek(FLASH_BASE, 8'h21);
    iap_q <= 1'b0;
    repeat (5) @(posedge REF_CLK);
  endtask
  task automatic t_guard;
    at(16'hefff, 8'h00);
    put(OFF_CTRL, 8'h01, 1'b1, 1'b0);
    rd(OFF_CTRL);
    chk(8'(v[CTRL_DENY_BIT]), 8'h01);
    peek(16'hefff, 8'h01);
  endtask
  task automatic t_protect;
    at(16'hefff, 8'h01);
    cmd(8'h08);
    rd(OFF_OPTION);
    chk(v, 8'h01);
    rd(OFF_CTRL);
    chk(8'(v[CTRL_PROT_BIT]), 8'h01);
    peek(16'hefff, 8'h00);
    at(16'hefff, 8'h00);
    cmd(8'h08);
    rd(OFF_OPTION);
    chk(v, 8'h00);
    peek(FLASH_BASE, ERASED_BYTE);
    peek(16'hefff, ERASED_BYTE);
    prog(16'hefff, 8'h33);
    peek(16'hefff, 8'h33);
  endtask
  task automatic t_link;
    app_q <= 1'b1;
    repeat (8) @(posedge REF_CLK);
    #1 chk(8'(app_i), 8'h01);
    attach <= 1'b1;
    repeat (40) @(posedge REF_CLK);
    #1 chk(8'(owned), 8'h01);
    chk(8'(app_i), 8'h00);
    rd(OFF_CTRL);
    chk(8'(v[CTRL_LINK_BIT]), 8'h01);
    prog(16'hf000, 8'h42);
    peek(16'hf000, 8'h42);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Wipe dominates the run; ceiling leaves ample margin
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    t_socket;
    t_iap;
    t_guard;
    t_protect;
    t_link;
    tally_and_finish;
  end
endmodule
